// ---- design/psa_arbiter.sv ----
`timescale 1ns/100ps
`include "psa_defines.svh"
// What this block does
// - overcharge preferred over overdischarge in progress
// - resume overdischarge after overcharge state set
// - late overdischarge: no standby, pull high
// - overcharge first releases the sense node
// - overcharge and overcurrent run in parallel
// - overcharge first interrupts overcurrent detection
// - overcurrent first pulls sense node low
// - overdischarge and overcurrent run in parallel
// - overdischarge first interrupts overcurrent detection
// - overdischarge after overcurrent: pull high, standby
// - overdischarge first: pull high, standby
// - short circuit evaluated independently of others
// - no excess charger during discharge faults
// - excess charger delay starts after discharge gate high
// - overcharge drives charge gate low after delay
// - overdischarge drives discharge gate low after delay
// - shorten mode cuts counter delays, not short
module psa_arbiter (
  input  wire logic                clock_i,
  input  wire logic                arst_n_i,
  input  wire psa_pkg::psa_cmp_type cmp_i,
  input  wire logic                shorten_i,
  output psa_pkg::psa_out_type     out_o
);
  import psa_pkg::*;

  localparam int OVC_N = `PSA_CYC(`PSA_OVC_DLY_US);
  localparam int ODC_N = `PSA_CYC(`PSA_ODC_DLY_US);
  localparam int OCR_N = `PSA_CYC(`PSA_OCR_DLY_US);
  localparam int SHT_N = `PSA_CYC(`PSA_SHT_DLY_US);
  localparam int XCH_N = `PSA_CYC(`PSA_XCH_DLY_US);
  localparam int REL_N = `PSA_CYC(`PSA_REL_DLY_US);

  // ==========================================================
  // input synchronisers
  psa_cmp_type cmp_m_q, cmp_s_q, cmp_m_d, cmp_s_d;
  logic        sh_m_q, sh_s_q, sh_m_d, sh_s_d;

  always_comb begin
    cmp_m_d = cmp_i;
    cmp_s_d = cmp_m_q;
    sh_m_d  = shorten_i;
    sh_s_d  = sh_m_q;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_m_q <= '0;
      cmp_s_q <= '0;
      sh_m_q  <= 1'b0;
      sh_s_q  <= 1'b0;
    end else begin
      cmp_m_q <= cmp_m_d;
      cmp_s_q <= cmp_s_d;
      sh_m_q  <= sh_m_d;
      sh_s_q  <= sh_s_d;
    end
  end

  // ==========================================================
  // delay helpers
  function automatic logic [`PSA_CNT_W-1:0] limit(input int n, input logic sh);
    int v;
    v = sh ? n / `PSA_SHORT_DIV : n;
    if (v < 1) v = 1;
    return v[`PSA_CNT_W-1:0];
  endfunction : limit

  // one step of a detect/release delay counter; returns next count, held at the limit
  function automatic logic [`PSA_CNT_W-1:0] step(input logic run, input logic [`PSA_CNT_W-1:0] c,
                                                 input logic [`PSA_CNT_W-1:0] lim);
    if (!run) return '0;
    if (c >= lim) return lim;
    return c + 1'b1;
  endfunction : step

  // ==========================================================
  // state
  logic ovc_q, ovc_d, odc_q, odc_d, ocr_q, ocr_d, sht_q, sht_d, xch_q, xch_d;
  psa_first_type first_q, first_d;
  logic [`PSA_CNT_W-1:0] c_ovc_q, c_ovc_d, c_odc_q, c_odc_d, c_ocr_q, c_ocr_d;
  logic [`PSA_CNT_W-1:0] c_sht_q, c_sht_d, c_xch_q, c_xch_d;
  psa_out_type out_q, out_d;

  logic ovc_run, odc_run, ocr_run, sht_run, xch_run;
  logic [`PSA_CNT_W-1:0] l_ovc, l_odc, l_ocr, l_sht, l_xch;

  always_comb begin
    ovc_d   = ovc_q;
    odc_d   = odc_q;
    ocr_d   = ocr_q;
    sht_d   = sht_q;
    xch_d   = xch_q;

    l_ovc = limit(ovc_q ? REL_N : OVC_N, sh_s_q);
    l_odc = limit(odc_q ? REL_N : ODC_N, sh_s_q);
    l_ocr = limit(ocr_q ? REL_N : OCR_N, sh_s_q);
    l_xch = limit(xch_q ? REL_N : XCH_N, sh_s_q);
    l_sht = limit(sht_q ? REL_N : SHT_N, 1'b0);

    // overcharge always runs, even beside an overcurrent state
    ovc_run = cmp_s_q.overcharge != ovc_q;
    // overdischarge suspended while overcharge is pending, resumes once it is set
    odc_run = (cmp_s_q.overdischarge != odc_q) && !(ovc_run && !ovc_q);
    // overcurrent interrupted once overcharge or overdischarge came first
    ocr_run = (cmp_s_q.overcurrent != ocr_q)
              && !(!ocr_q && (ovc_q || odc_q));
    sht_run = cmp_s_q.short_circuit != sht_q;
    // charger check blocked while discharge gate is low
    xch_run = (cmp_s_q.excess_charger != xch_q)
              && !(odc_q || ocr_q || sht_q) && out_q.discharge_gate;

    c_ovc_d = step(ovc_run, c_ovc_q, l_ovc);
    c_odc_d = step(odc_run, c_odc_q, l_odc);
    c_ocr_d = step(ocr_run, c_ocr_q, l_ocr);
    c_sht_d = step(sht_run, c_sht_q, l_sht);
    c_xch_d = step(xch_run, c_xch_q, l_xch);

    if (ovc_run && c_ovc_q >= l_ovc) ovc_d = ~ovc_q;
    if (odc_run && c_odc_q >= l_odc) odc_d = ~odc_q;
    if (ocr_run && c_ocr_q >= l_ocr) ocr_d = ~ocr_q;
    if (sht_run && c_sht_q >= l_sht) sht_d = ~sht_q;
    if (xch_run && c_xch_q >= l_xch) xch_d = ~xch_q;
    // a discharge fault completing in the same cycle must win, or the charge gate would blip low
    if (odc_q || ocr_q || sht_q || odc_d || ocr_d || sht_d) xch_d = 1'b0;
  end

  // ==========================================================
  // first established state
  always_comb begin
    first_d = first_q;
    // cleared when all three drop
    if (!(ovc_d || odc_d || ocr_d)) first_d = PSA_FIRST_NONE;
    else if (first_q == PSA_FIRST_NONE) begin
      if (ovc_d) first_d = PSA_FIRST_OVC;
      else if (odc_d) first_d = PSA_FIRST_ODC;
      else first_d = PSA_FIRST_OCR;
    end
  end

  // ==========================================================
  // gate, pull and standby outputs
  always_comb begin
    out_d.charge_gate    = !(ovc_q || xch_q);
    out_d.discharge_gate = !(odc_q || ocr_q || sht_q);
    out_d.standby        = 1'b0;
    out_d.pull           = PSA_PULL_NONE;
    case (first_q)
      PSA_FIRST_OVC: begin
        out_d.pull = odc_q ? PSA_PULL_HIGH : PSA_PULL_NONE;
      end
      PSA_FIRST_ODC: begin
        // the record can outlive the overdischarge state while overcharge is still held
        if (odc_q) begin
          out_d.pull    = PSA_PULL_HIGH;
          out_d.standby = 1'b1;
        end
      end
      PSA_FIRST_OCR: begin
        if (odc_q) begin
          out_d.pull    = PSA_PULL_HIGH;
          out_d.standby = 1'b1;
        end else if (ovc_q) out_d.pull = PSA_PULL_LOW;
        else if (ocr_q) out_d.pull = PSA_PULL_LOW;
      end
      default: begin
        out_d.pull = PSA_PULL_NONE;
      end
    endcase
    // overcharge suppresses standby only when it came first
    if (ovc_q && odc_q && first_q == PSA_FIRST_OVC) out_d.standby = 1'b0;
    if (sht_q && !odc_q) out_d.pull = PSA_PULL_LOW;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovc_q   <= 1'b0;
      odc_q   <= 1'b0;
      ocr_q   <= 1'b0;
      sht_q   <= 1'b0;
      xch_q   <= 1'b0;
      c_ovc_q <= '0;
      c_odc_q <= '0;
      c_ocr_q <= '0;
      c_sht_q <= '0;
      c_xch_q <= '0;
    end else begin
      ovc_q   <= ovc_d;
      odc_q   <= odc_d;
      ocr_q   <= ocr_d;
      sht_q   <= sht_d;
      xch_q   <= xch_d;
      c_ovc_q <= c_ovc_d;
      c_odc_q <= c_odc_d;
      c_ocr_q <= c_ocr_d;
      c_sht_q <= c_sht_d;
      c_xch_q <= c_xch_d;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_q <= PSA_FIRST_NONE;
    end else begin
      first_q <= first_d;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_q <= '{charge_gate: 1'b1, discharge_gate: 1'b1, pull: PSA_PULL_NONE, standby: 1'b0};
    end else begin
      out_q <= out_d;
    end
  end

  assign out_o = out_q;
endmodule : psa_arbiter

// ---- design/psa_defines.svh ----
`ifndef PSA_DEFINES_SVH
`define PSA_DEFINES_SVH
// ==========================================================
// timing
`define PSA_CLK_NS        40
// delay times in microseconds, as plain defaults
`define PSA_OVC_DLY_US    1000
`define PSA_ODC_DLY_US    1000
`define PSA_OCR_DLY_US    100
`define PSA_SHT_DLY_US    8
`define PSA_XCH_DLY_US    1000
`define PSA_REL_DLY_US    100
// cycle counts: least times round up
`define PSA_CYC(us)       (((us) * 1000 + `PSA_CLK_NS - 1) / `PSA_CLK_NS)
// divisor applied in shorten mode to counter-derived delays other than the short circuit ones
`define PSA_SHORT_DIV     64
`define PSA_CNT_W         20
`endif

// ---- design/psa_pkg.sv ----
package psa_pkg;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic overcharge;
    logic overdischarge;
    logic overcurrent;
    logic short_circuit;
    logic excess_charger;
  } psa_cmp_type;

  typedef enum logic [1:0] {PSA_PULL_NONE, PSA_PULL_LOW, PSA_PULL_HIGH} psa_pull_type;

  typedef struct packed {
    logic         charge_gate;
    logic         discharge_gate;
    psa_pull_type pull;
    logic         standby;
  } psa_out_type;

  // which of the overlapping states came first
  typedef enum logic [1:0] {PSA_FIRST_NONE, PSA_FIRST_OVC, PSA_FIRST_ODC, PSA_FIRST_OCR} psa_first_type;
endpackage : psa_pkg

// ---- bench/psa_arbiter_properties.sv ----
`timescale 1ns/100ps
module psa_arbiter_properties (
  input wire logic                 clock_i,
  input wire logic                 arst_n_i,
  input wire psa_pkg::psa_cmp_type cmp_i,
  input wire logic                 shorten_i,
  input wire psa_pkg::psa_out_type out_o
);
  import psa_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================================
  // short input run length, saturating
  logic [8:0] sc_q;
  logic [8:0] sc_d;
  always_comb begin
    sc_d = cmp_i.short_circuit ? sc_q + {8'h00, sc_q != 9'h1ff} : 9'h000;
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) sc_q <= 9'h000;
    else sc_q <= sc_d;
  end
  a_short_fast: assert property (sc_q == 9'h0d2 |-> !out_o.discharge_gate)
    else $error("short circuit not acted on in time");
  a_standby_pull: assert property (out_o.standby |-> out_o.pull == PSA_PULL_HIGH)
    else $error("standby without supply pull");
  a_standby_gate: assert property (out_o.standby |-> !out_o.discharge_gate)
    else $error("standby with discharge gate on");
  a_pull_high_gate: assert property (out_o.pull == PSA_PULL_HIGH |-> !out_o.discharge_gate)
    else $error("supply pull without discharge fault");
  a_cgate_cause: assert property (
    $fell(out_o.charge_gate) |-> $past(cmp_i.overcharge, 3) || $past(cmp_i.excess_charger, 3))
    else $error("charge gate dropped without cause");
  a_dgate_cause: assert property (
    $fell(out_o.discharge_gate) |-> $past(cmp_i.overdischarge, 3)
    || $past(cmp_i.overcurrent, 3) || $past(cmp_i.short_circuit, 3))
    else $error("discharge gate dropped without cause");
  a_pull_low_cause: assert property (
    $rose(out_o.pull == PSA_PULL_LOW) |->
    !out_o.standby && ($past(cmp_i.overcurrent, 3) || $past(cmp_i.short_circuit, 3)))
    else $error("low rail pull without discharge current fault");
  a_excess_after_dout: assert property (
    $fell(out_o.charge_gate) && !$past(cmp_i.overcharge, 3)
    |-> $past(out_o.discharge_gate))
    else $error("excess charger acted while discharge gate low");
endmodule : psa_arbiter_properties

// ---- bench/psa_pack_model.sv ----
`timescale 1ns/100ps
module psa_pack_model (
  input  wire logic                 clock_i,
  input  wire psa_pkg::psa_cmp_type want_i,
  input  wire logic                 charger_i,
  input  wire psa_pkg::psa_out_type gates_i,
  output psa_pkg::psa_cmp_type      cmp_o
);
  import psa_pkg::*;
  psa_cmp_type cmp_d;
  always_comb begin
    cmp_d = want_i;
    // charging through an off discharge fet sits near -Vf and trips the excess comparator
    if (charger_i && !gates_i.discharge_gate) cmp_d.excess_charger = 1'b1;
  end
  always_ff @(posedge clock_i) cmp_o <= cmp_d;
endmodule : psa_pack_model

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
`include "psa_defines.svh"
module testbench;
  import psa_pkg::*;
  localparam int OW = `PSA_CYC(`PSA_OVC_DLY_US) / `PSA_SHORT_DIV + 10;
  localparam int CW = `PSA_CYC(`PSA_OCR_DLY_US) / `PSA_SHORT_DIV + 10;
  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        shorten_i = 1'b1;
  logic        charger_i = 1'b0;
  psa_cmp_type want = '0;
  psa_cmp_type cmp_i;
  psa_out_type out_o;
  int          failures = 0;
  int          samples_checked = 0;
  always #20 clock_i = ~clock_i;
  psa_pack_model u_psa_pack_model (.clock_i(clock_i), .want_i(want), .charger_i(charger_i), .gates_i(out_o),
    .cmp_o(cmp_i));
  psa_arbiter u_psa_arbiter (.clock_i(clock_i), .arst_n_i(arst_n_i), .cmp_i(cmp_i), .shorten_i(shorten_i),
    .out_o(out_o));
  function automatic psa_out_type o(logic c, logic d, psa_pull_type p, logic s);
    o = '{c, d, p, s};
  endfunction : o
  task automatic check(input string what, input psa_out_type seen, input psa_out_type exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step
  task automatic restart(input string name);
    $display("test %s", name);
    want = '0;
    charger_i = 1'b0;
    arst_n_i = 1'b0;
    step(10);
    arst_n_i = 1'b1;
  endtask : restart
  // ==========================================================
  // scenarios
  task automatic t_ovc_first;
    restart("ovc_first");
    want.overdischarge = 1'b1;
    step(OW / 2);
    want.overcharge = 1'b1;
    step(OW);
    check("ovc_over_odc", out_o, o(1'b0, 1'b1, PSA_PULL_NONE, 1'b0));
    want.overcurrent = 1'b1;
    step(CW);
    check("ocr_cut", out_o, o(1'b0, 1'b1, PSA_PULL_NONE, 1'b0));
    step(OW);
    check("odc_late", out_o, o(1'b0, 1'b0, PSA_PULL_HIGH, 1'b0));
    $display("ovc_first done");
  endtask : t_ovc_first
  task automatic t_ocr_first;
    restart("ocr_first");
    want.overcurrent = 1'b1;
    step(CW);
    check("ocr", out_o, o(1'b1, 1'b0, PSA_PULL_LOW, 1'b0));
    want.overdischarge = 1'b1;
    step(OW);
    check("odc_after", out_o, o(1'b1, 1'b0, PSA_PULL_HIGH, 1'b1));
    restart("ocr_ovc");
    want.overcurrent = 1'b1;
    step(CW);
    want.overcharge = 1'b1;
    step(OW);
    check("ovc_after", out_o, o(1'b0, 1'b0, PSA_PULL_LOW, 1'b0));
    $display("ocr_first done");
  endtask : t_ocr_first
  task automatic t_odc_first;
    restart("odc_first");
    // the excess comparator trips through the model once the discharge fet is off
    charger_i = 1'b1;
    want.overdischarge = 1'b1;
    step(OW);
    want.overcurrent = 1'b1;
    step(OW);
    check("odc", out_o, o(1'b1, 1'b0, PSA_PULL_HIGH, 1'b1));
    want.excess_charger = 1'b1;
    want.overdischarge = 1'b0;
    step(CW);
    // overcurrent was refused, so only its fresh count runs now and has not yet ended
    check("dout_back", out_o, o(1'b1, 1'b1, PSA_PULL_NONE, 1'b0));
    want.overcurrent = 1'b0;
    step(OW);
    check("excess", out_o, o(1'b0, 1'b1, PSA_PULL_NONE, 1'b0));
    $display("odc_first done");
  endtask : t_odc_first
  task automatic t_short;
    restart("short");
    want.overcharge = 1'b1;
    step(20);
    want.short_circuit = 1'b1;
    step(`PSA_CYC(`PSA_SHT_DLY_US) / 2);
    check("short_wait", out_o, o(1'b1, 1'b1, PSA_PULL_NONE, 1'b0));
    step(`PSA_CYC(`PSA_SHT_DLY_US) / 2 + 20);
    check("short", out_o, o(1'b1, 1'b0, PSA_PULL_LOW, 1'b0));
    $display("short done");
  endtask : t_short
  task automatic t_normal;
    shorten_i = 1'b0;
    restart("normal");
    want.overcurrent = 1'b1;
    step(CW);
    check("ocr_normal_wait", out_o, o(1'b1, 1'b1, PSA_PULL_NONE, 1'b0));
    step(`PSA_CYC(`PSA_OCR_DLY_US));
    check("ocr_normal", out_o, o(1'b1, 1'b0, PSA_PULL_LOW, 1'b0));
    $display("normal done");
  endtask : t_normal
  task automatic print_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    t_ovc_first();
    t_ocr_first();
    t_odc_first();
    t_short();
    t_normal();
    print_verdict();
  end
  initial begin
    #(40 * 20000);
    failures++;
    print_verdict();
  end
endmodule : testbench
bind psa_arbiter psa_arbiter_properties u_psa_arbiter_properties (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .cmp_i(cmp_i), .shorten_i(shorten_i), .out_o(out_o));
